// *** hdl/tbdw_pkg.sv ***
// Constants and types for the terminal bus diagnostic word block
package tbdw_pkg;

    // Clock and measurement unit
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned TICK_US     = 100;
    localparam int unsigned TICK_CYC    = (CLK_HZ / 1_000_000) * TICK_US;

    // Field layout of the status and control words
    localparam int unsigned WORD_W      = 32;
    localparam int unsigned FIELD_W     = 8;
    localparam int unsigned BIT_RESET   = 0;
    localparam int unsigned BIT_REBOOT  = 1;
    localparam int unsigned BIT_STOP    = 3;
    localparam int unsigned BIT_SEL     = 6;
    localparam int unsigned POS_CYCLE   = 8;
    localparam int unsigned POS_CODE    = 16;
    localparam int unsigned POS_ARG     = 24;
    localparam logic [31:0] CTRL_MASK   = 32'h0000_004b;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;

    // Error codes
    localparam logic [7:0] CODE_NONE    = 8'h00;
    localparam logic [7:0] CODE_CFG     = 8'h01;
    localparam logic [7:0] CODE_TABLE   = 8'h02;
    localparam logic [7:0] CODE_CMD     = 8'h03;
    localparam logic [7:0] CODE_BREAK   = 8'h04;
    localparam logic [7:0] CODE_REGCOM  = 8'h05;
    localparam logic [7:0] CODE_INTERN  = 8'h06;
    localparam logic [7:0] CODE_FORMAT  = 8'h0e;
    localparam logic [7:0] CODE_COUNT   = 8'h0f;
    localparam logic [7:0] CODE_LENGTH  = 8'h10;

    // Fixed arguments
    localparam logic [7:0] ARG_ZERO     = 8'h00;
    localparam logic [7:0] ARG_OVERFLOW = 8'h01;
    localparam logic [7:0] ARG_BADTYPE  = 8'h02;
    localparam logic [7:0] ARG_DATA_A   = 8'h01;
    localparam logic [7:0] ARG_ADDRSW   = 8'h04;
    localparam logic [7:0] ARG_DATA_B   = 8'h08;
    localparam logic [7:0] ARG_SOCKET   = 8'h10;

    // Fault kinds reported by the terminal bus engine and coupler core
    typedef enum logic [3:0] {
        TBDW_F_CHECKSUM = 4'h0,
        TBDW_F_OVERFLOW = 4'h1,
        TBDW_F_BADTYPE  = 4'h2,
        TBDW_F_TABLE    = 4'h3,
        TBDW_F_CMD      = 4'h4,
        TBDW_F_BREAK    = 4'h5,
        TBDW_F_REGCOM   = 4'h6,
        TBDW_F_INIT     = 4'h7,
        TBDW_F_DATA_A   = 4'h8,
        TBDW_F_ADDRSW   = 4'h9,
        TBDW_F_DATA_B   = 4'ha,
        TBDW_F_SOCKET   = 4'hb,
        TBDW_F_FORMAT   = 4'hc,
        TBDW_F_COUNT    = 4'hd,
        TBDW_F_LENGTH   = 4'he
    } tbdw_fault_t;

    // Cycle time meter states
    typedef enum logic [1:0] {
        TBDW_M_IDLE = 2'b01,
        TBDW_M_RUN  = 2'b10
    } tbdw_meter_st_t;

endpackage

// *** hdl/tbdw_meter_if.sv ***
// Interface between the diagnostic word core and the cycle time meter
`timescale 1ns/1ns
interface tbdw_meter_if;
    logic       cycle_done;
    logic [7:0] cycle_time;

    modport core  (output cycle_done, input  cycle_time);
    modport meter (input  cycle_done, output cycle_time);
endinterface

// *** hdl/tbdw_cycle_meter.sv ***
// Terminal bus cycle time meter in 0.1 ms units
`timescale 1ns/1ns
module tbdw_cycle_meter
    import tbdw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    tbdw_meter_if.meter mif
);

    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_chk
        $error("TICK_CYCLES out of range");
    end

    localparam logic [15:0] PRE_LAST = 16'(TICK_CYCLES - 1);

    tbdw_meter_st_t st_q;
    tbdw_meter_st_t st_d;
    logic [15:0]    pre_q;
    logic [15:0]    pre_d;
    logic [7:0]     ticks_q;
    logic [7:0]     ticks_d;
    logic [7:0]     time_q;
    logic [7:0]     time_d;

    // Prescaler, tick count and capture at each cycle end after the first
    always_comb begin
        st_d    = st_q;
        pre_d   = pre_q;
        ticks_d = ticks_q;
        time_d  = time_q;
        if (mif.cycle_done) begin
            if (st_q == TBDW_M_RUN) begin
                time_d = ticks_q;
            end
            st_d    = TBDW_M_RUN;
            pre_d   = 16'h0000;
            ticks_d = 8'h00;
        end else if (pre_q == PRE_LAST) begin
            pre_d = 16'h0000;
            if (ticks_q != 8'hff) begin
                ticks_d = ticks_q + 8'h01; // Saturates at 25.5 ms
            end
        end else begin
            pre_d = pre_q + 16'h0001;
        end
    end

    // State registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= TBDW_M_IDLE;
            pre_q   <= 16'h0000;
            ticks_q <= 8'h00;
            time_q  <= 8'h00;
        end else begin
            st_q    <= st_d;
            pre_q   <= pre_d;
            ticks_q <= ticks_d;
            time_q  <= time_d;
        end
    end

    assign mif.cycle_time = time_q;

endmodule

// *** hdl/tbdw_top.sv ***
// Diagnostic and control word logic of the terminal bus coupler
`timescale 1ns/1ns
module tbdw_top
    import tbdw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,

    // Control word from the fieldbus controller
    input  wire logic        ctrl_word_valid,
    input  wire logic [31:0] ctrl_word,

    // Terminal bus cycle end
    input  wire logic        tbus_cycle_done,

    // Fault reports from the terminal bus engine and coupler core
    input  wire logic        fault_valid,
    input  wire tbdw_fault_t fault_kind,
    input  wire logic [7:0]  fault_term,

    // Controller and fieldbus state
    input  wire logic        fieldbus_err,
    input  wire logic        ctrl_stop,

    // Status word and action requests
    output logic      [31:0] status_word_q,
    output logic             tbus_reset_req_q,
    output logic             coupler_reboot_req_q,
    output logic             tbus_halt_q
);

    // Parameter and field layout checks
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_chk
        $error("TICK_CYCLES out of range");
    end
    if (WORD_W != 32 || FIELD_W != 8) begin : g_width
        $error("Status word layout must be 32 bits with byte fields");
    end
    if (POS_ARG + FIELD_W > WORD_W) begin : g_arg_fit
        $error("Argument field does not fit the status word");
    end
    if (POS_CODE + FIELD_W > POS_ARG) begin : g_code_fit
        $error("Code field overlaps the argument field");
    end
    if (POS_CYCLE + FIELD_W > POS_CODE) begin : g_cycle_fit
        $error("Cycle field overlaps the code field");
    end
    if (BIT_SEL >= POS_CYCLE || BIT_STOP >= POS_CYCLE) begin : g_flag_fit
        $error("Flag bits overlap the cycle field");
    end
    if (BIT_RESET == BIT_REBOOT || BIT_STOP == BIT_SEL) begin : g_bit_apart
        $error("Flag bits must be distinct");
    end
    if (CTRL_MASK != ((32'h0000_0001 << BIT_SEL) | (32'h0000_0001 << BIT_STOP)
                    | (32'h0000_0001 << BIT_REBOOT) | (32'h0000_0001 << BIT_RESET))) begin : g_mask
        $error("Control mask does not match the flag positions");
    end

    // Fault encoder: kind and terminal number to argument and code
    function automatic logic [15:0] encode_fault(
        input tbdw_fault_t kind,
        input logic [7:0]  term
    );
        logic [7:0] arg;
        logic [7:0] code;
        arg  = ARG_ZERO;
        code = CODE_NONE;
        // One code and argument per fault kind
        unique case (kind)
            // Configuration memory checksum
            TBDW_F_CHECKSUM: begin
                code = CODE_CFG;
                arg  = ARG_ZERO;
            end

            // Code table overflow
            TBDW_F_OVERFLOW: begin
                code = CODE_CFG;
                arg  = ARG_OVERFLOW;
            end

            // Unknown data type
            TBDW_F_BADTYPE: begin
                code = CODE_CFG;
                arg  = ARG_BADTYPE;
            end

            // Table mismatch at terminal n
            TBDW_F_TABLE: begin
                code = CODE_TABLE;
                arg  = term;
            end

            // Terminal bus command fault
            TBDW_F_CMD: begin
                code = CODE_CMD;
                arg  = ARG_ZERO;
            end

            // Break after the coupler or after terminal n
            TBDW_F_BREAK: begin
                code = CODE_BREAK;
                arg  = term;
            end

            // Register access fault at terminal n
            TBDW_F_REGCOM: begin
                code = CODE_REGCOM;
                arg  = term;
            end

            // Coupler start-up fault
            TBDW_F_INIT: begin
                code = CODE_INTERN;
                arg  = ARG_ZERO;
            end

            // First internal data fault
            TBDW_F_DATA_A: begin
                code = CODE_INTERN;
                arg  = ARG_DATA_A;
            end

            // Address switch not usable for boot addressing
            TBDW_F_ADDRSW: begin
                code = CODE_INTERN;
                arg  = ARG_ADDRSW;
            end

            // Second internal data fault
            TBDW_F_DATA_B: begin
                code = CODE_INTERN;
                arg  = ARG_DATA_B;
            end

            // Network socket fault
            TBDW_F_SOCKET: begin
                code = CODE_INTERN;
                arg  = ARG_SOCKET;
            end

            // Wrong data format at terminal n
            TBDW_F_FORMAT: begin
                code = CODE_FORMAT;
                arg  = term;
            end

            // Terminal count changed
            TBDW_F_COUNT: begin
                code = CODE_COUNT;
                arg  = term;
            end

            // Data length changed
            TBDW_F_LENGTH: begin
                code = CODE_LENGTH;
                arg  = term;
            end

            // Undefined kind
            default: begin
                code = CODE_NONE; // Undefined kind is dropped
                arg  = ARG_ZERO;
            end
        endcase
        // Argument in the upper byte, code in the lower
        return {arg, code};
    endfunction

    // Meter link
    tbdw_meter_if mif ();

    // Cycle end event into the meter
    assign mif.cycle_done = tbus_cycle_done;

    // Cycle time meter, runs independent of halt
    tbdw_cycle_meter #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_meter (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .mif      (mif)
    );

    // Control word state
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic        rst_req_d;
    logic        reboot_req_d;
    logic        halt_d;

    // Error state
    logic [7:0]  err_code_q;
    logic [7:0]  err_code_d;
    logic [7:0]  err_arg_q;
    logic [7:0]  err_arg_d;
    logic [15:0] err_enc;

    // Cycle counter and status image
    logic [7:0]  cyc_cnt_q;
    logic [7:0]  cyc_cnt_d;
    logic [31:0] status_d;

    // Control word capture and edge detection
    always_comb begin
        // Hold the last word between receptions
        ctrl_d       = ctrl_q;
        rst_req_d    = 1'b0;
        reboot_req_d = 1'b0;
        if (ctrl_word_valid) begin
            // Take a new word with unused bits masked
            ctrl_d = ctrl_word & CTRL_MASK;
            // Compare against the previous word so a held level does nothing
            rst_req_d    = ~ctrl_q[BIT_RESET] & ctrl_word[BIT_RESET];
            reboot_req_d = ctrl_q[BIT_REBOOT] & ~ctrl_word[BIT_REBOOT];
        end
    end

    // Halt of terminal bus cycling
    always_comb begin
        halt_d = ctrl_q[BIT_STOP] & (fieldbus_err | ctrl_stop);
    end

    // Control registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q               <= WORD_RST;
            tbus_reset_req_q     <= 1'b0;
            coupler_reboot_req_q <= 1'b0;
            tbus_halt_q          <= 1'b0;
        end else begin
            ctrl_q               <= ctrl_d;
            tbus_reset_req_q     <= rst_req_d;
            coupler_reboot_req_q <= reboot_req_d;
            tbus_halt_q          <= halt_d;
        end
    end

    // Error latch: last fault shown, cleared by bus reset, a new fault wins
    always_comb begin
        // Encode the reported fault
        err_enc    = encode_fault(fault_kind, fault_term);
        err_code_d = err_code_q;
        err_arg_d  = err_arg_q;
        if (fault_valid && err_enc[7:0] != CODE_NONE) begin
            // A new fault wins over the clear
            err_code_d = err_enc[7:0];
            err_arg_d  = err_enc[15:8];
        end else if (rst_req_d) begin
            // Bus reset request clears the error
            err_code_d = CODE_NONE;
            err_arg_d  = ARG_ZERO;
        end
    end

    // Error registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_code_q <= CODE_NONE;
            err_arg_q  <= ARG_ZERO;
        end else begin
            err_code_q <= err_code_d;
            err_arg_q  <= err_arg_d;
        end
    end

    // Cycle counter, wraps after 255
    always_comb begin
        cyc_cnt_d = cyc_cnt_q;
        if (tbus_cycle_done) begin
            // Count each finished cycle
            cyc_cnt_d = cyc_cnt_q + 8'h01;
        end
    end

    // Status word image
    always_comb begin
        // Unused bits stay zero
        status_d                          = WORD_RST;
        // Error argument and code
        status_d[POS_ARG +: FIELD_W]      = err_arg_q;
        status_d[POS_CODE +: FIELD_W]     = err_code_q;
        // Counter or measured cycle time
        status_d[POS_CYCLE +: FIELD_W]    = ctrl_q[BIT_SEL] ? mif.cycle_time : cyc_cnt_q;
        // Echo of the stored control flags
        status_d[BIT_SEL]                 = ctrl_q[BIT_SEL];
        status_d[BIT_STOP]                = ctrl_q[BIT_STOP];
        status_d[BIT_REBOOT]              = ctrl_q[BIT_REBOOT];
        status_d[BIT_RESET]               = ctrl_q[BIT_RESET];
    end

    // Counter and status registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_cnt_q     <= 8'h00;
            status_word_q <= WORD_RST;
        end else begin
            cyc_cnt_q     <= cyc_cnt_d;
            status_word_q <= status_d;
        end
    end

endmodule

// *** tb/tbdw_top_monitor.sv ***
// Port checker for the diagnostic word block
`timescale 1ns/1ns
module tbdw_top_monitor
    import tbdw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        ctrl_word_valid,
    input wire logic [31:0] ctrl_word,
    input wire logic        tbus_cycle_done,
    input wire logic        fault_valid,
    input wire tbdw_fault_t fault_kind,
    input wire logic [7:0]  fault_term,
    input wire logic        fieldbus_err,
    input wire logic        ctrl_stop,
    input wire logic [31:0] status_word_q,
    input wire logic        tbus_reset_req_q,
    input wire logic        coupler_reboot_req_q,
    input wire logic        tbus_halt_q
);
    logic [11:0] img_q;
    logic [11:0] img_d;
    logic        rise_c;
    logic        fall_c;

    // Image of count, select, stop and last request bits
    always_comb begin
        img_d = img_q;
        if (ctrl_word_valid) begin
            img_d[3:0] = {ctrl_word[6], ctrl_word[3], ctrl_word[1:0]};
        end
        if (tbus_cycle_done) begin
            img_d[11:4] = img_q[11:4] + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            img_q <= 12'h000;
        end else begin
            img_q <= img_d;
        end
    end

    // Edges against the previous control word
    assign rise_c = ctrl_word_valid & ctrl_word[0] & ~img_q[0];
    assign fall_c = ctrl_word_valid & ~ctrl_word[1] & img_q[1];

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    reset_pulse_a: assert property (tbus_reset_req_q == $past(rise_c))
        else $error("bus reset request mismatch");
    reboot_pulse_a: assert property (coupler_reboot_req_q == $past(fall_c))
        else $error("reboot request mismatch");
    unused_zero_a: assert property ((status_word_q & 32'h0000_00b4) == 32'h0000_0000)
        else $error("unused status bit set");
    flag_echo_a: assert property ({status_word_q[6], status_word_q[3], status_word_q[1:0]} == $past(img_q[3:0]))
        else $error("status flags differ from control word");
    halt_level_a: assert property (tbus_halt_q == $past(img_q[2] & (fieldbus_err | ctrl_stop)))
        else $error("halt level mismatch");
    cycle_count_a: assert property (!$past(img_q[3]) |-> status_word_q[15:8] == $past(img_q[11:4]))
        else $error("cycle counter mismatch");
    error_hold_a: assert property (!$past(fault_valid, 2) && !$past(rise_c, 2) |-> $stable(status_word_q[31:16]))
        else $error("error fields changed without cause");
    error_clear_a: assert property ($past(rise_c, 2) && !$past(fault_valid, 2) |-> status_word_q[31:16] == 16'h0000)
        else $error("error fields not cleared");
endmodule

bind tbdw_top tbdw_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_tbdw_top_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .ctrl_word_valid(ctrl_word_valid), .ctrl_word(ctrl_word),
    .tbus_cycle_done(tbus_cycle_done), .fault_valid(fault_valid), .fault_kind(fault_kind),
    .fault_term(fault_term), .fieldbus_err(fieldbus_err), .ctrl_stop(ctrl_stop),
    .status_word_q(status_word_q), .tbus_reset_req_q(tbus_reset_req_q),
    .coupler_reboot_req_q(coupler_reboot_req_q), .tbus_halt_q(tbus_halt_q));

// *** tb/tbdw_ctrl_model.sv ***
// Controller model sending cyclic control words
`timescale 1ns/1ns
module tbdw_ctrl_model (
    input  wire logic core_clk,
    output logic      ctrl_word_valid,
    output logic [31:0] ctrl_word
);
    // Idle at time zero
    initial begin
        ctrl_word_valid = 1'b0;
        ctrl_word = 32'h0000_0000;
    end

    // One word per call, stale data inverted after the cycle
    task automatic send(input logic [31:0] w);
        @(negedge core_clk);
        ctrl_word_valid = 1'b1;
        ctrl_word = w;
        @(negedge core_clk);
        ctrl_word_valid = 1'b0;
        ctrl_word = ~w;
    endtask
endmodule

// *** tb/tb_top.sv ***
// Testbench for the diagnostic word block
`timescale 1ns/1ns
module tb_top
    import tbdw_pkg::*;
;
    localparam int unsigned TICK = 4;
    logic        core_clk = 1'b0;
    logic        rst_n, ctrl_word_valid, tbus_cycle_done, fault_valid, fieldbus_err, ctrl_stop;
    logic [31:0] ctrl_word, status_word_q;
    tbdw_fault_t fault_kind;
    logic [7:0]  fault_term;
    logic        tbus_reset_req_q, coupler_reboot_req_q, tbus_halt_q;
    int          failures, checks_done;

    tbdw_ctrl_model i_tbdw_ctrl_model (.core_clk(core_clk), .ctrl_word_valid(ctrl_word_valid),
        .ctrl_word(ctrl_word));
    tbdw_top #(.TICK_CYCLES(TICK)) i_tbdw_top (.core_clk(core_clk), .rst_n(rst_n),
        .ctrl_word_valid(ctrl_word_valid), .ctrl_word(ctrl_word), .tbus_cycle_done(tbus_cycle_done),
        .fault_valid(fault_valid), .fault_kind(fault_kind), .fault_term(fault_term),
        .fieldbus_err(fieldbus_err), .ctrl_stop(ctrl_stop), .status_word_q(status_word_q),
        .tbus_reset_req_q(tbus_reset_req_q), .coupler_reboot_req_q(coupler_reboot_req_q),
        .tbus_halt_q(tbus_halt_q));

    // Clock
    always #25 core_clk = ~core_clk;

    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One fault report, error fields checked two cycles on
    task automatic fault(input tbdw_fault_t k, input logic [7:0] n, input logic [15:0] ex);
        fault_valid = 1'b1;
        fault_kind = k;
        fault_term = n;
        step(1);
        fault_valid = 1'b0;
        fault_term = ~n;
        step(2);
        chk("error fields", {16'h0000, ex}, {16'h0000, status_word_q[31:16]});
    endtask

    // Control word, then request pulses and low status byte
    task automatic ctl(input logic [31:0] w, input logic rs, input logic rb, input logic [7:0] lo);
        i_tbdw_ctrl_model.send(w);
        chk("request pulses", {30'h0, rs, rb}, {30'h0, tbus_reset_req_q, coupler_reboot_req_q});
        step(1);
        chk("status low byte", {24'h0, lo}, {24'h0, status_word_q[7:0]});
    endtask

    task automatic t_faults();
        logic [15:0] ex [15] = '{16'h0100, 16'h0101, 16'h0102, 16'h02ff, 16'h0300, 16'h04ff, 16'h05ff,
            16'h0600, 16'h0601, 16'h0604, 16'h0608, 16'h0610, 16'h0eff, 16'h0fff, 16'h10ff};
        logic [7:0] a;
        for (int k = 0; k < 15; k++) begin
            a = (ex[k][7:0] == 8'hff) ? 8'(k + 3) : ex[k][7:0];
            fault(tbdw_fault_t'(k), 8'(k + 3), {a, ex[k][15:8]});
        end
        fault(TBDW_F_BREAK, 8'h00, 16'h0004);
        fault(tbdw_fault_t'(4'hf), 8'h07, 16'h0004);
        $display("t_faults done");
    endtask

    task automatic t_ctrl();
        ctl(32'hffff_ffb5, 1'b1, 1'b0, 8'h01);
        chk("error cleared", 32'h0, {16'h0, status_word_q[31:16]});
        ctl(32'h0000_0001, 1'b0, 1'b0, 8'h01);
        ctl(32'h0000_0002, 1'b0, 1'b0, 8'h02);
        ctl(32'h0000_0000, 1'b0, 1'b1, 8'h00);
        $display("t_ctrl done");
    endtask

    task automatic t_halt();
        ctl(32'h0000_0008, 1'b0, 1'b0, 8'h08);
        ctrl_stop = 1'b1;
        step(2);
        chk("halt on stop", 32'h1, {31'h0, tbus_halt_q});
        ctrl_stop = 1'b0;
        fieldbus_err = 1'b1;
        step(2);
        chk("halt on fieldbus error", 32'h1, {31'h0, tbus_halt_q});
        ctl(32'h0000_0000, 1'b0, 1'b0, 8'h00);
        chk("no halt without stop flag", 32'h0, {31'h0, tbus_halt_q});
        fieldbus_err = 1'b0;
        $display("t_halt done");
    endtask

    task automatic pulse(input int n);
        tbus_cycle_done = 1'b1;
        step(n);
        tbus_cycle_done = 1'b0;
    endtask

    task automatic t_cycle();
        pulse(3);
        step(2);
        chk("cycle counter", 32'h3, {24'h0, status_word_q[15:8]});
        ctl(32'h0000_0040, 1'b0, 1'b0, 8'h40);
        pulse(1);
        step(41);
        pulse(1);
        step(2);
        chk("cycle time", 32'd10, {24'h0, status_word_q[15:8]});
        step(1100);
        pulse(1);
        step(2);
        chk("cycle time saturated", 32'hff, {24'h0, status_word_q[15:8]});
        rst_n = 1'b0;
        step(1);
        chk("status in reset", 32'h0, status_word_q);
        rst_n = 1'b1;
        step(2);
        chk("status after reset", 32'h0, status_word_q);
        $display("t_cycle done");
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        close_out();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        tbus_cycle_done = 1'b0;
        fault_valid = 1'b0;
        fault_kind = TBDW_F_CHECKSUM;
        fault_term = 8'h00;
        fieldbus_err = 1'b0;
        ctrl_stop = 1'b0;
        step(3);
        rst_n = 1'b1;
        step(1);
        t_faults();
        t_ctrl();
        t_halt();
        t_cycle();
        close_out();
    end
endmodule
